/* File: rtl/jasg_gate.sv */
/*
  Security gate for the serial programming port: pin dedication, enable
  register, read-out security, sector protection and blank state.
  Assumes a decoded command request from the serial engine and a host
  register write strobe, all on clock.
*/
// Function
// - With security set, every memory read is refused.
// - With security set, only full chip erase is accepted over the port.
// - A full chip erase clears security and leaves the device blank.
// - Each sector has a protect bit that blocks its erasure.
// - In the blank state every memory and logic bit reads as one.
// - In the blank state all configuration bits are zero.
// - Bit 0 of the enable register turns the port on or off.
// - With the nonvolatile dedicate bit, system reset does not stop the port.
// - With register enable only, system reset aborts and blocks the port.
// - Pins are dedicated when dedicate bit, enable bit or product term holds.
// - Any reset clears the enable bit, and software may clear it.
// - Undedicated pins are released for general-purpose use.
// - The data output stays input until the enabling command arrives.
`default_nettype none
module jasg_gate
  import jasg_pkg::*;
#(
  parameter int SECTORS = 12
) (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst_b,
  input  wire logic               sys_reset_b,
  // host enable register
  input  wire logic               reg_wr,
  input  wire logic [7:0]         reg_wdata,
  output logic [7:0]              reg_rdata,
  // configuration sources
  input  wire logic               nvm_dedicate,
  input  wire logic               pin_select_product_term,
  input  wire logic               security_nvm,
  input  wire logic [SECTORS-1:0] protect_nvm,
  input  wire logic               blank_nvm,
  // port pins
  input  wire jasg_pins_t         pins_in,
  input  wire logic               tdo_data,
  output logic                    tdo_out,
  output logic                    tdo_oe,
  output logic                    port_dedicated,
  output logic                    gpio_release,
  output jasg_pins_t              pins_sync,
  // command path from the serial engine
  input  wire jasg_req_t          req,
  output logic                    op_grant,
  output logic                    op_blocked,
  output logic                    chip_erase_go,
  output logic                    sect_erase_go,
  output logic [7:0]              sect_erase_idx,
  // array read path
  input  wire logic [7:0]         array_rdata,
  output logic [7:0]              read_data,
  output logic                    secured,
  output logic                    blank,
  output logic [7:0]              cfg_mask
);
  initial begin
    if (SECTORS < 1 || SECTORS > 256) $error("SECTORS out of range");
  end

  jasg_state_t state_ff, nxt_state;
  logic enable_ff, secure_ff, blank_ff, sys_rst_q, loaded_ff;
  logic [SECTORS-1:0] protect_ff;
  logic [7:0]         rdata_ff;
  logic               tdo_ff;
  logic               tdo_oe_ff;

  // reset request crosses inverted so the cleared flops read as idle
  jasg_sync #(.WIDTH(4)) u_sync (
    .clock    (clock),
    .rst_b    (rst_b),
    .async_in ({pins_in, ~sys_reset_b}),
    .sync_out ({pins_sync, sys_rst_q})
  );

  wire sys_rst_act   = sys_rst_q;
  wire reg_only      = enable_ff && !nvm_dedicate && !pin_select_product_term;
  wire dedicate      = nvm_dedicate || enable_ff || pin_select_product_term;
  // dedicate bit keeps port alive in reset
  wire port_killed   = sys_rst_act && !nvm_dedicate && !pin_select_product_term;
  wire port_live     = dedicate && !port_killed;
  wire cmd_valid     = req.valid && (state_ff == JASG_ST_ACTIVE);
  wire is_chip_erase = req.cmd == JASG_CMD_CHIP_ERASE;
  wire is_sect_erase = req.cmd == JASG_CMD_SECT_ERASE;
  wire sect_in_range = {24'h000000, req.sector} < SECTORS;
  // padded so any sector code indexes safely; out of range counts as protected
  wire [255:0] protect_full = 256'(protect_ff);
  wire sect_prot     = !sect_in_range || protect_full[req.sector];
  wire sec_block     = secure_ff && !is_chip_erase && req.cmd != JASG_CMD_NOP;
  wire prot_block    = is_sect_erase && sect_prot;
  wire grant         = cmd_valid && !sec_block && !prot_block && req.cmd != JASG_CMD_NOP;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      JASG_ST_OFF:    if (port_live) nxt_state = JASG_ST_LISTEN;
      // drive data out only after enabling command
      JASG_ST_LISTEN: if (!port_live) nxt_state = JASG_ST_OFF;
                      else if (req.valid && req.cmd == JASG_CMD_PORT_ON)
                        nxt_state = JASG_ST_ACTIVE;
      JASG_ST_ACTIVE: if (!port_live) nxt_state = JASG_ST_OFF;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_ff <= JASG_ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // reset clears enable; host write loads it from the write data
  // bit 0 is the port switch
  always_ff @(posedge clock) begin
    if (!rst_b || sys_rst_act) begin
      enable_ff <= JASG_ENABLE_RESET[JASG_ENABLE_BIT];
    end else if (reg_wr) begin
      enable_ff <= reg_wdata[JASG_ENABLE_BIT];
    end
  end

  // chip erase clears security and protection
  // blocked commands change nothing
  // nvm image loaded once after release, a strap caught on the clock
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      loaded_ff  <= 1'b0;
      secure_ff  <= 1'b0;
      blank_ff   <= 1'b1;
      protect_ff <= '0;
    end else if (!loaded_ff) begin
      loaded_ff  <= 1'b1;
      secure_ff  <= security_nvm;
      blank_ff   <= blank_nvm;
      protect_ff <= protect_nvm;
    end else if (grant && is_chip_erase) begin
      secure_ff  <= 1'b0;
      blank_ff   <= 1'b1;
      protect_ff <= '0;
    end else if (grant && req.cmd == JASG_CMD_PROGRAM) begin
      blank_ff   <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rdata_ff <= JASG_BLANK_BYTE;
    end else if (secure_ff || blank_ff) begin
      rdata_ff <= JASG_BLANK_BYTE;
    end else begin
      rdata_ff <= array_rdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tdo_ff    <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      tdo_ff    <= tdo_data;
      tdo_oe_ff <= nxt_state == JASG_ST_ACTIVE;
    end
  end

  assign cfg_mask       = blank_ff ? JASG_CFG_BLANK : 8'hFF;
  assign reg_rdata      = {7'h00, enable_ff};
  assign tdo_out        = tdo_ff;
  // pin let go in the same cycle the dedication drops
  assign tdo_oe         = tdo_oe_ff && port_live;
  assign port_dedicated = port_live;
  assign gpio_release   = !dedicate;
  assign op_grant       = grant;
  assign op_blocked     = cmd_valid && !grant && req.cmd != JASG_CMD_NOP;
  assign chip_erase_go  = grant && is_chip_erase;
  assign sect_erase_go  = grant && is_sect_erase;
  assign sect_erase_idx = req.sector;
  assign read_data      = rdata_ff;
  assign secured        = secure_ff;
  assign blank          = blank_ff;

  AST_SEC_ONLY_ERASE: assert property (@(posedge clock) disable iff (!rst_b)
    secure_ff && op_grant |-> is_chip_erase) else $error("secured port granted non-erase");
  AST_SEC_READ: assert property (@(posedge clock) disable iff (!rst_b)
    $past(secure_ff) && secure_ff |-> read_data == 8'hFF) else $error("secured read leaked");
  AST_ERASE_CLR: assert property (@(posedge clock) disable iff (!rst_b)
    loaded_ff && chip_erase_go |=> !secure_ff && blank_ff) else $error("erase left security");
  AST_PROT: assert property (@(posedge clock) disable iff (!rst_b)
    sect_erase_go |-> !sect_prot) else $error("protected sector erased");
  AST_CFG_BLANK: assert property (@(posedge clock) disable iff (!rst_b)
    blank_ff |-> cfg_mask == 8'h00) else $error("blank config not zero");
  AST_EN_WR: assert property (@(posedge clock) disable iff (!rst_b)
    reg_wr && !sys_rst_act |=> enable_ff == $past(reg_wdata[0])) else $error("enable bit wrong");
  AST_NVM_RST: assert property (@(posedge clock) disable iff (!rst_b)
    nvm_dedicate |-> port_dedicated) else $error("reset stopped dedicated port");
  AST_NVM_KEEP: assert property (@(posedge clock) disable iff (!rst_b)
    nvm_dedicate && state_ff == JASG_ST_ACTIVE |=> state_ff == JASG_ST_ACTIVE)
    else $error("dedicated session dropped");
  AST_REG_RST: assert property (@(posedge clock) disable iff (!rst_b)
    reg_only && sys_rst_act |=> !op_grant && !enable_ff) else $error("reset failed to abort");
  AST_GPIO: assert property (@(posedge clock) disable iff (!rst_b)
    gpio_release |-> !tdo_oe) else $error("pin driven while released");
  AST_TDO: assert property (@(posedge clock) disable iff (!rst_b)
    state_ff == JASG_ST_LISTEN && !(req.valid && req.cmd == JASG_CMD_PORT_ON)
      |=> !tdo_oe) else $error("tdo driven before enable");
  AST_BLOCK: assert property (@(posedge clock) disable iff (!rst_b)
    loaded_ff && op_blocked |=> secure_ff == $past(secure_ff) && blank_ff == $past(blank_ff))
    else $error("blocked command changed state");
endmodule
`default_nettype wire

/* File: rtl/jasg_pkg.sv */
/*
  Package for the serial programming port security gate: register layout,
  reset values, command encodings and gate states.
  Assumes one synchronous clock domain; the test clock is sampled as data.
*/
`default_nettype none
package jasg_pkg;
  localparam int          JASG_ENABLE_BIT     = 0;
  localparam logic [7:0]  JASG_ENABLE_RESET   = 8'h00;
  localparam logic [7:0]  JASG_BLANK_BYTE     = 8'hFF;
  localparam logic [7:0]  JASG_CFG_BLANK      = 8'h00;
  localparam int          JASG_SYNC_STAGES    = 2;

  typedef enum logic [2:0] {
    JASG_CMD_NOP,
    JASG_CMD_READ,
    JASG_CMD_PROGRAM,
    JASG_CMD_SECT_ERASE,
    JASG_CMD_VERIFY,
    JASG_CMD_CHIP_ERASE,
    JASG_CMD_PORT_ON
  } jasg_cmd_t;

  typedef enum logic [1:0] {
    JASG_ST_OFF,
    JASG_ST_LISTEN,
    JASG_ST_ACTIVE
  } jasg_state_t;

  typedef struct packed {
    logic        tms;
    logic        tck;
    logic        tdi;
  } jasg_pins_t;

  typedef struct packed {
    logic        valid;
    jasg_cmd_t   cmd;
    logic [7:0]  sector;
  } jasg_req_t;
endpackage
`default_nettype wire

/* File: rtl/jasg_sync.sv */
/*
  Two-stage synchroniser bank for the port pins.
  Assumes inputs are asynchronous to clock.
*/
`default_nettype none
module jasg_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule
`default_nettype wire

/* File: tb/jasg_ctrl_model.sv */
/*
  Model of the external programming controller: one command per call.
  Assumes the caller sits 1 ns after a rising edge of clock.
*/
`default_nettype none
module jasg_ctrl_model
  import jasg_pkg::*;
(
  // clock
  input  wire logic        clock,
  // gate answer {grant, blocked, chip go, sector go, index}
  input  wire logic [11:0] ans,
  // controller outputs
  output var  jasg_req_t   req,
  output var  jasg_pins_t  pins
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    req = '0;
    pins = '0;
  end
  // held one whole cycle; test clock idles low between commands
  task automatic send(input jasg_cmd_t c, input logic [7:0] s, output logic [11:0] a);
    @(posedge clock);
    #1 req = '{1'b1, c, s};
    pins = '{c[0], 1'b1, c[1]};
    #1 a = ans;
    @(posedge clock);
    #1 req.valid = 1'b0;
    pins = '{~c[0], 1'b0, ~c[1]};
  endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
/*
  Self-checking bench for the port security gate.
  Assumes the controller model and the gate's built-in assertions.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import jasg_pkg::*;
  logic        clock = 1'b0, rst_b = 1'b0, sys_reset_b = 1'b1, reg_wr = 1'b0;
  logic        nvm_dedicate = 1'b0, pin_select_product_term = 1'b0, tdo_data = 1'b0;
  logic        security_nvm = 1'b0, blank_nvm = 1'b1;
  logic [7:0]  reg_wdata = 8'h00, array_rdata = 8'h00;
  logic [11:0] protect_nvm = 12'h000, ans, a;
  logic [7:0]  reg_rdata, read_data, sect_erase_idx, cfg_mask;
  logic        tdo_out, tdo_oe, port_dedicated, gpio_release, op_grant, op_blocked;
  logic        chip_erase_go, sect_erase_go, secured, blank;
  logic [3:0]  k;
  jasg_pins_t  pins_in, pins_sync;
  jasg_req_t   req;
  int          err_total = 0, num_checks = 0, seed_v;
  always #2 clock = ~clock;
  assign ans = {op_grant, op_blocked, chip_erase_go, sect_erase_go, sect_erase_idx};
  jasg_gate #(.SECTORS(12)) i_dut (.clock, .rst_b, .sys_reset_b, .reg_wr, .reg_wdata,
    .reg_rdata, .nvm_dedicate, .pin_select_product_term, .security_nvm, .protect_nvm,
    .blank_nvm, .pins_in, .tdo_data, .tdo_out, .tdo_oe, .port_dedicated, .gpio_release,
    .pins_sync, .req, .op_grant, .op_blocked, .chip_erase_go, .sect_erase_go,
    .sect_erase_idx, .array_rdata, .read_data, .secured, .blank, .cfg_mask);
  jasg_ctrl_model i_ctrl (.clock(clock), .ans(ans), .req(req), .pins(pins_in));
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_ans(input logic [11:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: answer got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [11:0] exp_ans(jasg_cmd_t c, logic sec, logic [7:0] s);
    logic bad;
    bad = (sec && c != JASG_CMD_CHIP_ERASE) ||
          (c == JASG_CMD_SECT_ERASE && (s > 8'h0B || protect_nvm[s[3:0]]));
    return {~bad, bad, ~bad && c == JASG_CMD_CHIP_ERASE, ~bad && c == JASG_CMD_SECT_ERASE, s};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic restart(input logic sec, blk, input logic [11:0] prot);
    security_nvm = sec;
    blank_nvm = blk;
    protect_nvm = prot;
    rst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    tick(2);
  endtask
  task automatic host_wr(input logic d);
    reg_wdata = {7'h00, d};
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic cmd(input jasg_cmd_t c, input logic [7:0] s, input logic sec);
    i_ctrl.send(c, s, a);
    chk_ans(a, exp_ans(c, sec, s));
  endtask
  initial begin
    #20000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    seed_v = $urandom(32'hDC8F);
    tick(0);
    restart(1'b0, 1'b1, 12'h000);
    chk(read_data, JASG_BLANK_BYTE, "blank read");
    chk(cfg_mask, JASG_CFG_BLANK, "blank cfg");
    chk(reg_rdata, JASG_ENABLE_RESET, "enable rst");
    for (int i = 0; i < 8; i++) begin
      nvm_dedicate = i[0];
      pin_select_product_term = i[1];
      host_wr(i[2]);
      chk(port_dedicated, |i[2:0], "dedicate");
      chk(gpio_release, ~|i[2:0], "release");
      chk(reg_rdata, {7'h00, i[2]}, "enable");
    end
    chk(tdo_oe, 1'b0, "oe early");
    i_ctrl.send(JASG_CMD_PORT_ON, 8'h00, a);
    chk(tdo_oe, 1'b1, "oe on");
    tdo_data = 1'($urandom);
    tick(1);
    chk(tdo_out, tdo_data, "tdo");
    restart(1'b1, 1'b0, 12'h000);
    array_rdata = 8'($urandom);
    i_ctrl.send(JASG_CMD_PORT_ON, 8'h00, a);
    chk(read_data, 8'hFF, "secure read");
    for (int c = 1; c < 5; c++) begin
      cmd(jasg_cmd_t'(c), 8'($urandom_range(11)), 1'b1);
    end
    chk(secured, 1'b1, "still secure");
    cmd(JASG_CMD_CHIP_ERASE, 8'h00, 1'b1);
    chk(secured, 1'b0, "erase unsecures");
    chk(blank, 1'b1, "erase blanks");
    k = 4'($urandom_range(11));
    restart(1'b0, 1'b0, 12'($urandom) | (12'h001 << k));
    i_ctrl.send(JASG_CMD_PORT_ON, 8'h00, a);
    tick(2);
    chk(read_data, array_rdata, "open read");
    chk({5'h00, pins_sync}, {5'h00, pins_in}, "pins sync");
    cmd(JASG_CMD_SECT_ERASE, {4'h0, k}, 1'b0);
    cmd(JASG_CMD_SECT_ERASE, 8'h0C, 1'b0);
    for (int i = 0; i < 8; i++) begin
      cmd(JASG_CMD_SECT_ERASE, 8'($urandom_range(11)), 1'b0);
    end
    nvm_dedicate = 1'b0;
    pin_select_product_term = 1'b0;
    host_wr(1'b1);
    i_ctrl.send(JASG_CMD_PORT_ON, 8'h00, a);
    chk(tdo_oe, 1'b1, "reg session");
    sys_reset_b = 1'b0;
    tick(3);
    chk(port_dedicated, 1'b0, "sysrst kill");
    chk(tdo_oe, 1'b0, "sysrst abort");
    chk(reg_rdata, 8'h00, "sysrst clear");
    host_wr(1'b1);
    chk(port_dedicated, 1'b0, "sysrst block");
    i_ctrl.send(JASG_CMD_READ, 8'h00, a);
    chk_ans(a, 12'h000);
    nvm_dedicate = 1'b1;
    tick(1);
    chk(port_dedicated, 1'b1, "nvm keeps");
    i_ctrl.send(JASG_CMD_PORT_ON, 8'h00, a);
    cmd(JASG_CMD_READ, 8'h00, 1'b0);
    sys_reset_b = 1'b1;
    tally_and_finish();
  end
endmodule
`default_nettype wire
